// file: logic/adc_ctl_pkg.sv
// Constants for the sample and conversion sequencing control block
package adc_ctl_pkg;
   localparam int REG_ADDR_WIDTH = 4;
   localparam logic [3:0] CONTROL_ONE_OFFSET = 4'h0;
   localparam logic [3:0] CONFIG_OFFSET = 4'h1;
   localparam logic [3:0] STATUS_OFFSET = 4'h2;
   localparam int DONE_BIT = 0;
   localparam int SAMPLE_ENABLE_BIT = 1;
   localparam int AUTO_START_BIT = 2;
   localparam int SIMULTANEOUS_BIT = 3;
   localparam int CHANNEL_COUNT_LSB = 0;
   localparam int TWELVE_BIT_POS = 2;
   localparam int TRIGGER_SOURCE_LSB = 3;
   localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   localparam logic [2:0] TRIGGER_SOFTWARE = 3'h0;
   localparam logic [1:0] CHANNELS_ONE = 2'h0;
   localparam logic [1:0] CHANNELS_TWO = 2'h1;
   localparam int CONVERT_CYCLES = 14;
   localparam int NUM_CHANNELS = 4;
   typedef enum logic [1:0] {
      IDLE = 2'b00,
      SAMPLING = 2'b01,
      CONVERTING = 2'b10
   } phase_type;
endpackage

// file: logic/channel_sequencer.sv
// Picks which channels are converted and in which order for one conversion cycle
`timescale 1ns/100ps
module channel_sequencer #(
   parameter int CHANNELS = adc_ctl_pkg::NUM_CHANNELS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic load,
   input wire logic advance,
   input wire logic simultaneous,
   input wire logic [1:0] channel_count,
   output logic [CHANNELS-1:0] channel_mask,
   output logic last
);
   logic [CHANNELS-1:0] pending;
   logic [CHANNELS-1:0] first_group;

   function automatic logic [CHANNELS-1:0] enabled_of(input logic [1:0] cnt);
      logic [CHANNELS-1:0] m;
      m = '0;
      m[0] = 1'b1;
      if (cnt == adc_ctl_pkg::CHANNELS_TWO) begin
         m[1] = 1'b1;
      end else if (cnt[1]) begin
         m = '1;
      end
      return m;
   endfunction

   // Simultaneous takes every enabled channel at once; else lowest first
   always_comb begin
      first_group = '0;
      if (simultaneous && channel_count != adc_ctl_pkg::CHANNELS_ONE) begin
         first_group = enabled_of(channel_count);
      end else begin
         first_group[0] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= '0;
         channel_mask <= '0;
         last <= 1'b0;
      end else if (clk_en) begin
         if (load) begin
            pending <= enabled_of(channel_count) & ~first_group;
            channel_mask <= first_group;
            last <= (enabled_of(channel_count) & ~first_group) == '0;
         end else if (advance && !last) begin
            // One channel per step in sequential mode
            channel_mask <= channel_mask << 1;
            pending <= pending & ~(channel_mask << 1);
            last <= (pending & ~(channel_mask << 1)) == '0;
         end
      end
   end
endmodule // channel_sequencer

// file: logic/adc_sample_convert_control.sv
// Sampling and conversion sequencing with the first control register
`timescale 1ns/100ps
// How it works
// - Simultaneous select only acts when channel count is 01 or 1x.
// - In twelve-bit mode simultaneous select ignores writes and reads zero.
// - Simultaneous: channels 0-3 together for 1x, 0 and 1 for 01.
// - Without simultaneous select, enabled channels convert one at a time.
// - Auto-start sets sample enable right after a conversion ends.
// - Without auto-start, only a software write of 1 begins sampling.
// - Sample enable reads 1 while sampling, 0 while holding.
// - With software trigger, writing 0 to sample enable starts conversion.
// - With hardware trigger, the trigger clears sample enable and converts.
// - Done flag sets when a conversion cycle completes, else reads 0.
// - Software may clear done but never set it.
// - Clearing done leaves sampling and conversion untouched.
// - Done clears automatically when a new conversion begins.
module adc_sample_convert_control #(
   parameter int CONVERT_CYCLES = adc_ctl_pkg::CONVERT_CYCLES,
   parameter int CHANNELS = adc_ctl_pkg::NUM_CHANNELS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [adc_ctl_pkg::REG_ADDR_WIDTH-1:0] address,
   input wire logic [15:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [15:0] read_data,
   input wire logic conversion_trigger,
   output logic sample_hold_sampling,
   output logic converter_start,
   output logic [CHANNELS-1:0] converter_channels
);
   localparam logic [7:0] CONVERT_LAST = 8'(CONVERT_CYCLES - 1);

   logic rst_sync1;
   logic rst_sync2;
   logic simultaneous_sample_select;
   logic auto_sample_start;
   logic sample_enable;
   logic done;
   logic [1:0] channel_count_select;
   logic twelve_bit_mode;
   logic [2:0] conversion_trigger_source;
   adc_ctl_pkg::phase_type phase;
   logic [7:0] convert_count;
   logic trigger_seen;
   logic seq_load;
   logic seq_advance;
   logic seq_last;
   logic [CHANNELS-1:0] seq_mask;
   logic write_ctl;
   logic write_cfg;
   logic sw_end_sample;
   logic hw_end_sample;
   logic start_convert;
   logic convert_step_end;
   logic cycle_complete;
   logic step_begin;
   logic [15:0] next_read_data;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync1 <= 1'b0;
         rst_sync2 <= 1'b0;
      end else begin
         rst_sync1 <= 1'b1;
         rst_sync2 <= rst_sync1;
      end
   end

   assign write_ctl = write_strobe && address == adc_ctl_pkg::CONTROL_ONE_OFFSET;
   assign write_cfg = write_strobe && address == adc_ctl_pkg::CONFIG_OFFSET;

   // Software end of sampling only counts in software-trigger mode
   assign sw_end_sample = write_ctl && !write_data[adc_ctl_pkg::SAMPLE_ENABLE_BIT]
      && sample_enable
      && conversion_trigger_source == adc_ctl_pkg::TRIGGER_SOFTWARE;
   assign hw_end_sample = trigger_seen && sample_enable
      && conversion_trigger_source != adc_ctl_pkg::TRIGGER_SOFTWARE;
   assign start_convert = phase == adc_ctl_pkg::SAMPLING && (sw_end_sample || hw_end_sample);
   assign convert_step_end = phase == adc_ctl_pkg::CONVERTING && convert_count == CONVERT_LAST;
   assign cycle_complete = convert_step_end && seq_last;
   assign seq_load = start_convert;
   assign seq_advance = convert_step_end;

   // Trigger pulse registered, acted on the following cycle
   always_ff @(posedge clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         trigger_seen <= 1'b0;
      end else if (clk_en) begin
         trigger_seen <= conversion_trigger;
      end
   end

   always_ff @(posedge clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         channel_count_select <= adc_ctl_pkg::CONFIG_RESET[1:0];
         twelve_bit_mode <= 1'b0;
         conversion_trigger_source <= 3'h0;
      end else if (clk_en && write_cfg) begin
         channel_count_select <= write_data[adc_ctl_pkg::CHANNEL_COUNT_LSB +: 2];
         twelve_bit_mode <= write_data[adc_ctl_pkg::TWELVE_BIT_POS];
         conversion_trigger_source <= write_data[adc_ctl_pkg::TRIGGER_SOURCE_LSB +: 3];
      end
   end

   always_ff @(posedge clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         simultaneous_sample_select <= 1'b0;
         auto_sample_start <= 1'b0;
      end else if (clk_en) begin
         if (write_ctl) begin
            auto_sample_start <= write_data[adc_ctl_pkg::AUTO_START_BIT];
            // Bit does not exist in twelve-bit mode
            simultaneous_sample_select <= !twelve_bit_mode
               && write_data[adc_ctl_pkg::SIMULTANEOUS_BIT];
         end else if (write_cfg && write_data[adc_ctl_pkg::TWELVE_BIT_POS]) begin
            simultaneous_sample_select <= 1'b0;
         end
      end
   end

   // Sample enable mirrors the front end: 1 sampling, 0 holding
   always_ff @(posedge clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         sample_enable <= 1'b0;
         phase <= adc_ctl_pkg::IDLE;
      end else if (clk_en) begin
         case (phase)
            adc_ctl_pkg::IDLE: begin
               if (auto_sample_start) begin
                  sample_enable <= 1'b1;
                  phase <= adc_ctl_pkg::SAMPLING;
               end else if (write_ctl && write_data[adc_ctl_pkg::SAMPLE_ENABLE_BIT]) begin
                  sample_enable <= 1'b1;
                  phase <= adc_ctl_pkg::SAMPLING;
               end
            end
            adc_ctl_pkg::SAMPLING: begin
               if (start_convert) begin
                  sample_enable <= 1'b0;
                  phase <= adc_ctl_pkg::CONVERTING;
               end
            end
            adc_ctl_pkg::CONVERTING: begin
               if (cycle_complete) begin
                  if (auto_sample_start) begin
                     sample_enable <= 1'b1;
                     phase <= adc_ctl_pkg::SAMPLING;
                  end else begin
                     phase <= adc_ctl_pkg::IDLE;
                  end
               end
            end
            default: begin
               sample_enable <= 1'b0;
               phase <= adc_ctl_pkg::IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         convert_count <= 8'h00;
      end else if (clk_en) begin
         if (start_convert || convert_step_end) begin
            convert_count <= 8'h00;
         end else if (phase == adc_ctl_pkg::CONVERTING) begin
            convert_count <= convert_count + 8'h01;
         end
      end
   end

   // Hardware set wins over a simultaneous software clear
   always_ff @(posedge clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         done <= 1'b0;
      end else if (clk_en) begin
         if (cycle_complete) begin
            done <= 1'b1;
         end else if (start_convert) begin
            done <= 1'b0;
         end else if (write_ctl && !write_data[adc_ctl_pkg::DONE_BIT]) begin
            done <= 1'b0;
         end
      end
   end

   channel_sequencer #(
      .CHANNELS(CHANNELS)
   ) sequencer (
      .clk(clk),
      .rst_n(rst_sync2),
      .clk_en(clk_en),
      .load(seq_load),
      .advance(seq_advance),
      .simultaneous(simultaneous_sample_select),
      .channel_count(channel_count_select),
      .channel_mask(seq_mask),
      .last(seq_last)
   );

   always_ff @(posedge clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         sample_hold_sampling <= 1'b0;
         step_begin <= 1'b0;
         converter_start <= 1'b0;
         converter_channels <= '0;
      end else if (clk_en) begin
         sample_hold_sampling <= sample_enable;
         // Start waits a cycle so the new channel mask stands beside it
         step_begin <= start_convert || (convert_step_end && !seq_last);
         converter_start <= step_begin;
         converter_channels <= (phase == adc_ctl_pkg::CONVERTING) ? seq_mask : '0;
      end
   end

   always_comb begin
      next_read_data = 16'h0000;
      if (address == adc_ctl_pkg::CONTROL_ONE_OFFSET) begin
         next_read_data[adc_ctl_pkg::SIMULTANEOUS_BIT] = simultaneous_sample_select
            && !twelve_bit_mode;
         next_read_data[adc_ctl_pkg::AUTO_START_BIT] = auto_sample_start;
         next_read_data[adc_ctl_pkg::SAMPLE_ENABLE_BIT] = sample_enable;
         next_read_data[adc_ctl_pkg::DONE_BIT] = done;
      end else if (address == adc_ctl_pkg::CONFIG_OFFSET) begin
         next_read_data[adc_ctl_pkg::CHANNEL_COUNT_LSB +: 2] = channel_count_select;
         next_read_data[adc_ctl_pkg::TWELVE_BIT_POS] = twelve_bit_mode;
         next_read_data[adc_ctl_pkg::TRIGGER_SOURCE_LSB +: 3] = conversion_trigger_source;
      end else if (address == adc_ctl_pkg::STATUS_OFFSET) begin
         next_read_data[1:0] = phase;
         next_read_data[4 +: CHANNELS] = seq_mask;
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_sync2) begin
      if (!rst_sync2) begin
         read_data <= 16'h0000;
      end else if (clk_en) begin
         read_data <= read_strobe ? next_read_data : 16'h0000;
      end
   end
endmodule // adc_sample_convert_control

// file: bench/sample_front_end_model.sv
// Front-end model that ends sampling with a hardware trigger pulse
`timescale 1ns/100ps
module sample_front_end_model #(
   parameter int SAMPLE_CYCLES = 10
) (
   input wire logic clk,
   input wire logic enable,
   input wire logic sampling,
   output logic trigger
);
   int count = 0;
   initial trigger = 1'b0;
   // Count is only equal once per phase, so the pulse is one cycle
   always @(posedge clk) begin
      count <= sampling ? count + 1 : 0;
      trigger <= enable && sampling && count == SAMPLE_CYCLES;
   end
endmodule // sample_front_end_model

// file: bench/adc_sample_convert_control_chk.sv
// Port-level assertions for the sample and conversion control block
`timescale 1ns/100ps
module adc_sample_convert_control_chk #(
   parameter int CHANNELS = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [adc_ctl_pkg::REG_ADDR_WIDTH-1:0] address,
   input wire logic [15:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [15:0] read_data,
   input wire logic conversion_trigger,
   input wire logic sample_hold_sampling,
   input wire logic converter_start,
   input wire logic [CHANNELS-1:0] converter_channels
);
   logic [5:0] cfg;
   logic sim;
   logic auto_on;
   wire ctl_wr = write_strobe && address == adc_ctl_pkg::CONTROL_ONE_OFFSET;
   // Twelve-bit mode masks the stored select bit
   wire sim_eff = sim && !cfg[2] && cfg[1:0] != 2'h0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cfg <= 6'h00;
      else if (write_strobe && address == adc_ctl_pkg::CONFIG_OFFSET) cfg <= write_data[5:0];
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) {sim, auto_on} <= 2'h0;
      else if (ctl_wr) {sim, auto_on} <= write_data[3:2];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence sw_end;
      ctl_wr && !write_data[1] && sample_hold_sampling && cfg[5:3] == 3'h0;
   endsequence
   sequence hw_end;
      conversion_trigger && sample_hold_sampling && cfg[5:3] != 3'h0;
   endsequence
   chk_unmapped_zero: assert property (read_strobe && address > 4'h2 |=> read_data == 16'h0000)
      else $error("unmapped read gave data");
   chk_sampling_idle: assert property (sample_hold_sampling |-> converter_channels == 4'h0)
      else $error("channels converted while sampling");
   chk_sim_group: assert property (converter_start && sim_eff |->
      converter_channels == (cfg[1] ? 4'hF : 4'h3)) else $error("wrong simultaneous group");
   chk_seq_single: assert property (converter_start && !sim_eff |->
      $onehot(converter_channels)) else $error("sequential step not one channel");
   chk_one_channel: assert property (converter_start && cfg[1:0] == 2'h0 |->
      converter_channels == 4'h1) else $error("single channel mode wrong");
   chk_hw_end: assert property (hw_end |-> ##[2:3] converter_start)
      else $error("trigger did not start conversion");
   chk_sw_end: assert property (sw_end |-> ##[1:2] converter_start)
      else $error("software end did not start conversion");
   chk_sw_start: assert property ($rose(sample_hold_sampling) && !auto_on |->
      $past(ctl_wr && write_data[1], 2)) else $error("sampling began without software");
endmodule // adc_sample_convert_control_chk
bind adc_sample_convert_control adc_sample_convert_control_chk #(.CHANNELS(CHANNELS)) i_chk (
   .clk(clk), .rst_n(rst_n), .address(address), .write_data(write_data),
   .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
   .conversion_trigger(conversion_trigger), .sample_hold_sampling(sample_hold_sampling),
   .converter_start(converter_start), .converter_channels(converter_channels));

// file: bench/adc_sample_convert_control_tb_top.sv
// Self-checking bench for the sample and conversion control block
`timescale 1ns/100ps
module adc_sample_convert_control_tb_top;
   localparam int CC = 8;
   logic clk = 1'b0, rst_n = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0, trig_en = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] address = 4'h0, converter_channels;
   logic [15:0] write_data = 16'h0000, read_data;
   logic conversion_trigger, sample_hold_sampling, converter_start;
   logic rd_pend = 1'b0, done_exp = 1'b0;
   logic [31:0] note;
   logic [31:0] rd_q[$];
   logic [3:0] ch_q[$];
   int error_cnt = 0, cmp_count = 0, cycles = 0;
   initial forever #4 clk = ~clk;
   adc_sample_convert_control #(.CONVERT_CYCLES(CC), .CHANNELS(4)) i_dut (.clk(clk),
      .rst_n(rst_n), .clk_en(clk_en), .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .conversion_trigger(conversion_trigger), .sample_hold_sampling(sample_hold_sampling),
      .converter_start(converter_start), .converter_channels(converter_channels));
   sample_front_end_model i_fe (.clk(clk), .enable(trig_en), .sampling(sample_hold_sampling),
      .trigger(conversion_trigger));
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [15:0] exp, logic [15:0] mask);
      rd_q.push_back({mask, exp & mask});
      @(posedge clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
   endtask
   task automatic drain();
      for (int i = 0; i < 400 && ch_q.size() > 0; i++) @(posedge clk);
      repeat (CC + 4) @(posedge clk);
      check("pending steps", 16'(ch_q.size()), 16'h0000);
   endtask
   // Done bit kept at 1 in the first two writes so only the clear cases can move it
   task automatic convert(logic [1:0] cnt, logic sim, logic twelve);
      logic simr;
      logic eff;
      int n;
      simr = sim && !twelve;
      eff = simr && cnt != 2'h0;
      n = cnt == 2'h0 ? 1 : (cnt == 2'h1 ? 2 : 4);
      wr(4'h1, {13'h0000, twelve, cnt});
      wr(4'h0, {12'h000, sim, 3'h3});
      rd(4'h0, {12'h000, simr, 2'h1, done_exp}, 16'h000F);
      check("sampling", {15'h0000, sample_hold_sampling}, 16'h0001);
      if (eff) ch_q.push_back(cnt[1] ? 4'hF : 4'h3);
      for (int i = 0; i < n && !eff; i++) ch_q.push_back(4'h1 << i);
      wr(4'h0, {12'h000, sim, 3'h1});
      rd(4'h0, {12'h000, simr, 3'h0}, 16'h000F);
      check("holding", {15'h0000, sample_hold_sampling}, 16'h0000);
      wr(4'h0, {12'h000, sim, 3'h0});
      drain();
      rd(4'h0, {12'h000, simr, 3'h1}, 16'h000F);
      done_exp = 1'b1;
   endtask
   always @(posedge clk) begin
      if (rd_pend) begin
         note = rd_q.pop_front();
         check("read_data", read_data & note[31:16], note[15:0]);
      end
      if (converter_start === 1'b1) check("channels", {12'h000, converter_channels},
         {12'h000, ch_q.pop_front()});
      rd_pend <= read_strobe;
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(32'h1073));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      rd(4'h0, adc_ctl_pkg::CONTROL_ONE_RESET, 16'hFFFF);
      rd(4'h1, adc_ctl_pkg::CONFIG_RESET, 16'hFFFF);
      rd(4'h2, 16'h0000, 16'h00F3);
      rd(4'h3 + 4'($urandom_range(12, 0)), 16'h0000, 16'hFFFF);
      // Frozen block must ignore a start request
      clk_en <= 1'b0;
      wr(4'h0, 16'h0002);
      clk_en <= 1'b1;
      rd(4'h0, 16'h0000, 16'h000F);
      for (int k = 0; k < 16; k++) convert(k[1:0], k[2], k[3]);
      repeat (6) convert(2'($urandom_range(3, 0)), 1'($urandom_range(1, 0)),
         1'($urandom_range(1, 0)));
      // Hardware trigger with auto restart, three rounds of two channels
      wr(4'h1, 16'h0039);
      trig_en <= 1'b1;
      repeat (6) ch_q.push_back(ch_q.size() % 2 == 0 ? 4'h1 : 4'h2);
      wr(4'h0, 16'h0004);
      drain();
      trig_en <= 1'b0;
      repeat (20) @(posedge clk);
      rd(4'h0, 16'h0007, 16'h000F);
      repeat (4) @(posedge clk);
      stop_test();
   end
endmodule // adc_sample_convert_control_tb_top
